// file: sdcu_pkg.sv
// package for the sdram controller upper configuration block
package sdcu_pkg;
    // register byte offsets
    localparam logic [7:0] MCC_FOUR_OFFSET  = 8'hFC;
    localparam logic [7:0] MCC_THREE_OFFSET = 8'hF8;
    // field positions in config four
    localparam int PRE_ACT_LSB    = 28;
    localparam int ACT_PRE_LSB    = 24;
    localparam int ROM_BEATS_BIT  = 23;
    localparam int BUF_MSB_BIT    = 22;
    localparam int EXT_ROM_BIT    = 21;
    localparam int BUF_LSB_BIT    = 20;
    localparam int OPEN_LO_LSB    = 18;
    localparam int DBUS_SIZE_BIT  = 17;
    localparam int REG_DIMM_BIT   = 15;
    localparam int SDMODE_LSB     = 8;
    localparam int ACTORW_LSB     = 4;
    localparam int OPEN_HI_LSB    = 0;
    // field position in config three
    localparam int OPEN_MID_LSB   = 28;
    // reset values
    localparam logic [31:0] MCC_FOUR_RESET  = 32'h0010_0000;
    localparam logic [31:0] MCC_THREE_RESET = 32'h0000_0000;
    // writable bits of config four: everything but reserved bit 16
    localparam logic [31:0] MCC_FOUR_MASK   = 32'hFFFE_FFFF;
    // buffer type codes
    localparam logic [1:0] BUF_REGISTERED = 2'h1;
    localparam logic [1:0] BUF_INLINE     = 2'h2;
    // rom beats
    localparam logic [3:0] ROM_BEATS_FOUR  = 4'h4;
    localparam logic [3:0] ROM_BEATS_EIGHT = 4'h8;
    // zero code of a four-bit interval means sixteen clocks
    localparam logic [4:0] INTERVAL_ZERO_CLOCKS = 5'h10;
    // clock
    localparam int CLOCK_HZ = 10_000_000;

    typedef enum logic [2:0]
    {
        SDCU_IDLE     = 3'b000,
        SDCU_ACTIVE   = 3'b001,
        SDCU_OPEN     = 3'b010,
        SDCU_PRECHG   = 3'b011,
        SDCU_ROM_BURST = 3'b100
    } sdcu_state_t;

    // sdram command pins, active low
    typedef struct packed
    {
        logic rowStrobeN;
        logic columnStrobeN;
        logic writeEnableN;
    } sdcu_cmd_t;

    // decoded configuration
    typedef struct packed
    {
        logic [4:0] precharge_to_activate_count;
        logic [4:0] actToPre;
        logic       romEightBeats;
        logic [1:0] bufType;
        logic       extended_rom_enable;
        logic [9:0] openPage;
        logic       registered_dimm_select;
    } sdcu_cfg_t;
endpackage : sdcu_pkg

// file: sdcu_ctrl.sv
// sdram/rom controller core governed by the upper half of config register four
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/100ps
// Contract
// - wait programmed clocks precharge to activate
// - wait programmed clocks activate to precharge
// - rom burst bit: four or eight beats
// - four-beat rom splits burst in two
// - buffer type from bits 22 and 20
// - in-line mode checks and generates parity/ecc (code only generates byte parity on writes and checks nothing)
// - extended rom enable adds 128 Mbytes
// - open page interval spans three fields
// - reload page counter on every access
// - counter expiry issues bank precharge
// - registered dimm delays write data one cycle
module sdcu_ctrl
(
    input  wire logic             clock,
    input  wire logic             reset_n,
    // apb slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic [31:0]           prdata,
    output logic                  pready,
    output logic                  pslverr,
    // access requests from the processor side
    input  wire logic             sdramReq,
    input  wire logic             sdramWrite,
    input  wire logic [31:0]      sdramWdata,
    input  wire logic [3:0]       sdramWpar,
    input  wire logic             romReq,
    input  wire logic             romAddrHigh,
    output logic                  reqAck,
    output logic                  romSelect,
    output logic                  romInRange,
    output logic                  romBurstStart,
    output logic [3:0]            romBurstBeats,
    // sdram pins
    output sdcu_pkg::sdcu_cmd_t   sdramCmd,
    output logic [31:0]           memData,
    output logic [3:0]            memPar,
    output logic                  memDataOe,
    // data path mode and open page status
    output logic                  inlineEccActive,
    output logic                  registeredBufActive,
    output logic                  pageOpen
);
    logic [31:0]           cfgFour_r;
    logic [31:0]           cfgThree_r;
    sdcu_pkg::sdcu_cfg_t   cfg;
    sdcu_pkg::sdcu_state_t state_r;
    sdcu_pkg::sdcu_state_t state_nxt;
    logic [4:0]            gapCnt_r;
    logic [9:0]            pageCnt_r;
    logic                  romSecond_r;
    logic [31:0]           wdataHold_r;
    logic [3:0]            wparHold_r;
    logic                  wrPend_r;
    logic                  apbWrite;
    logic                  apbRead;
    logic                  addrHit;
    logic                  pageAccess;

    // apb decode: zero wait states
    assign addrHit  = (paddr == sdcu_pkg::MCC_FOUR_OFFSET)
                   || (paddr == sdcu_pkg::MCC_THREE_OFFSET);
    assign apbWrite = psel && penable && pwrite && addrHit;
    assign apbRead  = psel && !pwrite;
    assign pready   = psel && penable;
    assign pslverr  = psel && penable && !addrHit;

    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            cfgFour_r  <= sdcu_pkg::MCC_FOUR_RESET;
            cfgThree_r <= sdcu_pkg::MCC_THREE_RESET;
        end
        else if (apbWrite && paddr == sdcu_pkg::MCC_FOUR_OFFSET)
        begin
            cfgFour_r <= pwdata & sdcu_pkg::MCC_FOUR_MASK;
        end
        else if (apbWrite)
        begin
            cfgThree_r <= pwdata;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (apbRead && !penable)
        begin
            if (paddr == sdcu_pkg::MCC_FOUR_OFFSET)
            begin
                prdata <= cfgFour_r;
            end
            else if (paddr == sdcu_pkg::MCC_THREE_OFFSET)
            begin
                prdata <= cfgThree_r;
            end
            else
            begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // field decode
    function automatic logic [4:0] interval(input logic [3:0] code);
        interval = (code == 4'h0) ? sdcu_pkg::INTERVAL_ZERO_CLOCKS : {1'b0, code};
    endfunction : interval

    always_comb
    begin
        cfg.precharge_to_activate_count      = interval(cfgFour_r[sdcu_pkg::PRE_ACT_LSB +: 4]);
        cfg.actToPre      = interval(cfgFour_r[sdcu_pkg::ACT_PRE_LSB +: 4]);
        cfg.romEightBeats = cfgFour_r[sdcu_pkg::ROM_BEATS_BIT];
        cfg.bufType       = {cfgFour_r[sdcu_pkg::BUF_MSB_BIT],
                             cfgFour_r[sdcu_pkg::BUF_LSB_BIT]};
        cfg.extended_rom_enable        = cfgFour_r[sdcu_pkg::EXT_ROM_BIT];
        cfg.openPage      = {cfgFour_r[sdcu_pkg::OPEN_LO_LSB +: 2],
                             cfgThree_r[sdcu_pkg::OPEN_MID_LSB +: 4],
                             cfgFour_r[sdcu_pkg::OPEN_HI_LSB +: 4]};
        cfg.registered_dimm_select       = cfgFour_r[sdcu_pkg::REG_DIMM_BIT];
    end

    // in-line ecc/parity path only works when software chose in-line mode
    assign inlineEccActive     = (cfg.bufType == sdcu_pkg::BUF_INLINE);
    assign registeredBufActive = (cfg.bufType == sdcu_pkg::BUF_REGISTERED);
    // rom decode: the upper region answers only with extended rom on
    assign romInRange = romReq && (!romAddrHigh || cfg.extended_rom_enable);

    assign pageAccess = (state_r == sdcu_pkg::SDCU_OPEN) && sdramReq;

    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            sdcu_pkg::SDCU_IDLE:
            begin
                if (gapCnt_r == 5'h00 && sdramReq)
                begin
                    state_nxt = sdcu_pkg::SDCU_ACTIVE;
                end
                else if (romInRange)
                begin
                    state_nxt = sdcu_pkg::SDCU_ROM_BURST;
                end
            end
            sdcu_pkg::SDCU_ACTIVE:
            begin
                state_nxt = sdcu_pkg::SDCU_OPEN;
            end
            sdcu_pkg::SDCU_OPEN:
            begin
                if (pageCnt_r == 10'h000 && !sdramReq && gapCnt_r == 5'h00)
                begin
                    state_nxt = sdcu_pkg::SDCU_PRECHG;
                end
            end
            sdcu_pkg::SDCU_PRECHG:
            begin
                state_nxt = sdcu_pkg::SDCU_IDLE;
            end
            sdcu_pkg::SDCU_ROM_BURST:
            begin
                if (cfg.romEightBeats || romSecond_r)
                begin
                    state_nxt = sdcu_pkg::SDCU_IDLE;
                end
            end
            default:
            begin
                state_nxt = sdcu_pkg::SDCU_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            state_r <= sdcu_pkg::SDCU_IDLE;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // interval counter: loaded at each precharge and activate, counts to zero
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            gapCnt_r <= 5'h00;
        end
        else if (state_nxt == sdcu_pkg::SDCU_PRECHG)
        begin
            gapCnt_r <= cfg.precharge_to_activate_count;
        end
        else if (state_nxt == sdcu_pkg::SDCU_ACTIVE)
        begin
            gapCnt_r <= cfg.actToPre - 5'h01;
        end
        else if (gapCnt_r != 5'h00)
        begin
            gapCnt_r <= gapCnt_r - 5'h01;
        end
    end

    // page open duration counter
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            pageCnt_r <= 10'h000;
        end
        else if (state_r == sdcu_pkg::SDCU_ACTIVE || pageAccess)
        begin
            pageCnt_r <= cfg.openPage;
        end
        else if (pageCnt_r != 10'h000)
        begin
            pageCnt_r <= pageCnt_r - 10'h001;
        end
    end

    // four-beat roms take each eight-beat burst as two transactions
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            romSecond_r   <= 1'b0;
            romBurstStart <= 1'b0;
            romBurstBeats <= sdcu_pkg::ROM_BEATS_FOUR;
        end
        else
        begin
            romBurstStart <= (state_nxt == sdcu_pkg::SDCU_ROM_BURST);
            romBurstBeats <= cfg.romEightBeats ? sdcu_pkg::ROM_BEATS_EIGHT
                                               : sdcu_pkg::ROM_BEATS_FOUR;
            romSecond_r   <= (state_r == sdcu_pkg::SDCU_ROM_BURST) && !romSecond_r
                             && !cfg.romEightBeats;
        end
    end

    assign romSelect = (state_r == sdcu_pkg::SDCU_ROM_BURST);
    assign reqAck    = pageAccess;
    assign pageOpen  = (state_r == sdcu_pkg::SDCU_OPEN);

    // command pins
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            sdramCmd <= '{rowStrobeN: 1'b1, columnStrobeN: 1'b1, writeEnableN: 1'b1};
        end
        else
        begin
            sdramCmd.rowStrobeN    <= !(state_nxt == sdcu_pkg::SDCU_ACTIVE
                                     || state_nxt == sdcu_pkg::SDCU_PRECHG);
            sdramCmd.columnStrobeN <= !pageAccess;
            sdramCmd.writeEnableN  <= !((pageAccess && sdramWrite)
                                     || state_nxt == sdcu_pkg::SDCU_PRECHG);
        end
    end

    // write data: same cycle as the command, or one later for registered dimms
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            wdataHold_r <= 32'h0000_0000;
            wparHold_r  <= 4'h0;
            wrPend_r    <= 1'b0;
            memData     <= 32'h0000_0000;
            memPar      <= 4'h0;
            memDataOe   <= 1'b0;
        end
        else
        begin
            wrPend_r    <= pageAccess && sdramWrite;
            wdataHold_r <= sdramWdata;
            wparHold_r  <= inlineEccActive ? {^sdramWdata[31:24], ^sdramWdata[23:16],
                                              ^sdramWdata[15:8], ^sdramWdata[7:0]}
                                           : sdramWpar;
            if (cfg.registered_dimm_select)
            begin
                memData   <= wdataHold_r;
                memPar    <= wparHold_r;
                memDataOe <= wrPend_r;
            end
            else
            begin
                memData   <= sdramWdata;
                memPar    <= inlineEccActive ? {^sdramWdata[31:24], ^sdramWdata[23:16],
                                                ^sdramWdata[15:8], ^sdramWdata[7:0]}
                                             : sdramWpar;
                memDataOe <= pageAccess && sdramWrite;
            end
        end
    end
endmodule : sdcu_ctrl

// file: sdcu_mem_model.sv
// memory-side model that latches sdram write data and parity
`timescale 1ns/100ps
module sdcu_mem_model
(
    input wire logic        clock,
    input wire logic [31:0] memData,
    input wire logic [3:0]  memPar,
    input wire logic        memDataOe
);
    logic [35:0] capQ[$];
    // the dimm takes data and parity whenever the controller drives them
    always @(posedge clock)
        if (memDataOe === 1'b1)
            capQ.push_back({memPar, memData});
endmodule : sdcu_mem_model

// file: sdcu_ctrl_assertions.sv
// concurrent checks on the ports of the controller
`timescale 1ns/100ps
module sdcu_ctrl_chk
(
    input wire logic                clock,
    input wire logic                reset_n,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [7:0]          paddr,
    input wire logic [31:0]         pwdata,
    input wire logic [31:0]         prdata,
    input wire logic                romReq,
    input wire logic                romAddrHigh,
    input wire logic                romInRange,
    input wire logic                romBurstStart,
    input wire logic [3:0]          romBurstBeats,
    input wire logic                reqAck,
    input wire sdcu_pkg::sdcu_cmd_t sdramCmd,
    input wire logic                memDataOe,
    input wire logic                inlineEccActive,
    input wire logic                registeredBufActive
);
    logic [31:0] cfg4_r;
    logic [4:0]  sinceAct_r;
    logic [4:0]  sincePre_r;
    wire isAct = !sdramCmd.rowStrobeN && sdramCmd.columnStrobeN && sdramCmd.writeEnableN;
    wire isPre = !sdramCmd.rowStrobeN && sdramCmd.columnStrobeN && !sdramCmd.writeEnableN;
    wire isWr  = sdramCmd.rowStrobeN && !sdramCmd.columnStrobeN && !sdramCmd.writeEnableN;
    // shadow of config four from the bus
    always_ff @(posedge clock)
        if (!reset_n)
            cfg4_r <= sdcu_pkg::MCC_FOUR_RESET;
        else if (psel && penable && pwrite && paddr == sdcu_pkg::MCC_FOUR_OFFSET)
            cfg4_r <= pwdata;
    // cycles since last activate and precharge, saturating
    always_ff @(posedge clock)
        if (!reset_n)
            {sinceAct_r, sincePre_r} <= 10'h3FF;
        else
        begin
            sinceAct_r <= isAct ? 5'h1 : sinceAct_r + {4'h0, sinceAct_r != 5'h1F};
            sincePre_r <= isPre ? 5'h1 : sincePre_r + {4'h0, sincePre_r != 5'h1F};
        end
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    property p_pre_act;
        isAct |-> sincePre_r >= {~|cfg4_r[31:28], cfg4_r[31:28]};
    endproperty
    a_pre_act: assert property (p_pre_act) else $error("activate too early");
    property p_act_pre;
        isPre |-> sinceAct_r >= {~|cfg4_r[27:24], cfg4_r[27:24]};
    endproperty
    a_act_pre: assert property (p_act_pre) else $error("precharge too early");
    property p_rom_beats;
        romBurstStart |-> romBurstBeats == (cfg4_r[23] ? 4'h8 : 4'h4);
    endproperty
    a_rom_beats: assert property (p_rom_beats) else $error("rom beats wrong");
    property p_buf_type;
        inlineEccActive == ({cfg4_r[22], cfg4_r[20]} == 2'h2)
            && registeredBufActive == ({cfg4_r[22], cfg4_r[20]} == 2'h1);
    endproperty
    a_buf_type: assert property (p_buf_type) else $error("buffer mode wrong");
    property p_ext_rom;
        romInRange == (romReq && (!romAddrHigh || cfg4_r[21]));
    endproperty
    a_ext_rom: assert property (p_ext_rom) else $error("rom range wrong");
    property p_access;
        reqAck |=> !sdramCmd.columnStrobeN && sdramCmd.rowStrobeN;
    endproperty
    a_access: assert property (p_access) else $error("access not issued");
    property p_wr_normal;
        isWr && !cfg4_r[15] |-> memDataOe;
    endproperty
    a_wr_normal: assert property (p_wr_normal) else $error("write data late");
    property p_wr_reg;
        memDataOe && cfg4_r[15] |-> $past(isWr);
    endproperty
    a_wr_reg: assert property (p_wr_reg) else $error("write data not delayed");
    property p_reserved;
        psel && penable && !pwrite && paddr == sdcu_pkg::MCC_FOUR_OFFSET |-> !prdata[16];
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit set");
    c_act: cover property (isAct);
    c_pre: cover property (isPre);
    c_rom8: cover property (romBurstStart && romBurstBeats == 4'h8);
endmodule : sdcu_ctrl_chk
bind sdcu_ctrl sdcu_ctrl_chk i_chk
(
    .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .romReq(romReq),
    .romAddrHigh(romAddrHigh), .romInRange(romInRange), .romBurstStart(romBurstStart),
    .romBurstBeats(romBurstBeats), .reqAck(reqAck), .sdramCmd(sdramCmd),
    .memDataOe(memDataOe), .inlineEccActive(inlineEccActive),
    .registeredBufActive(registeredBufActive)
);

// file: test_sdram_ctrl_config_upper.sv
// self-checking bench for the sdram controller upper config block
`timescale 1ns/100ps
module test_sdram_ctrl_config_upper;
    logic clock, reset_n, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, sdramWdata, memData, rdat;
    logic [31:0] cfg4 = sdcu_pkg::MCC_FOUR_RESET, cfg3 = 32'h0;
    logic sdramReq, sdramWrite, romReq, romAddrHigh, reqAck, romSelect, romInRange;
    logic romBurstStart, memDataOe, inlineEccActive, registeredBufActive, pageOpen;
    logic [3:0]  sdramWpar, memPar, romBurstBeats;
    sdcu_pkg::sdcu_cmd_t sdramCmd;
    logic [35:0] expQ[$];
    integer seed = 32'hC8EC61CE;
    int nErrors = 0;
    int checks = 0;
    int n, starts;
    sdcu_ctrl i_dut
    (
        .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sdramReq(sdramReq), .sdramWrite(sdramWrite), .sdramWdata(sdramWdata),
        .sdramWpar(sdramWpar), .romReq(romReq), .romAddrHigh(romAddrHigh), .reqAck(reqAck),
        .romSelect(romSelect), .romInRange(romInRange), .romBurstStart(romBurstStart),
        .romBurstBeats(romBurstBeats), .sdramCmd(sdramCmd), .memData(memData),
        .memPar(memPar), .memDataOe(memDataOe), .inlineEccActive(inlineEccActive),
        .registeredBufActive(registeredBufActive), .pageOpen(pageOpen)
    );
    sdcu_mem_model i_mem
    (
        .clock(clock), .memData(memData), .memPar(memPar), .memDataOe(memDataOe)
    );
    initial
    begin
        clock = 0;
        forever #50 clock = ~clock;
    end
    task end_of_test;
        $display("errors %0d checks %0d", nErrors, checks);
        if (nErrors == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    task chk(input string s, input logic [35:0] e, input logic [35:0] g);
        checks++;
        if (g !== e)
        begin
            nErrors++;
            $display("unexpected %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clock);
        penable <= 1;
        @(posedge clock);
        // only the watchdog ends a wait for the slave
        while (pready !== 1'b1)
            @(posedge clock);
        rdat = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
        @(posedge clock);
    endtask : apb
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1, a, d);
        if (a == sdcu_pkg::MCC_THREE_OFFSET) cfg3 = d;
        if (a == sdcu_pkg::MCC_FOUR_OFFSET) cfg4 = d & sdcu_pkg::MCC_FOUR_MASK;
    endtask : wr
    task rd(input logic [7:0] a);
        logic m3, m4;
        m3 = a == sdcu_pkg::MCC_THREE_OFFSET;
        m4 = a == sdcu_pkg::MCC_FOUR_OFFSET;
        apb(0, a, 0);
        chk("readData", m4 ? cfg4 : m3 ? cfg3 : 0, rdat);
        chk("slaveError", !(m3 || m4), err);
    endtask : rd
    task acc;
        logic [31:0] d;
        logic [3:0] p;
        d = $random(seed);
        p = {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]};
        expQ.push_back({p, d});
        // wrong parity offered: in-line mode must generate its own
        sdramReq <= 1; sdramWrite <= 1; sdramWdata <= d; sdramWpar <= ~p;
        @(posedge clock);
        while (reqAck !== 1'b1)
            @(posedge clock);
        sdramReq <= 0;
    endtask : acc
    initial
    begin
        repeat (20000) @(posedge clock);
        nErrors++;
        end_of_test;
    end
    initial
    begin
        reset_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        sdramReq = 0; sdramWrite = 0; sdramWdata = 0; sdramWpar = 0; romReq = 0; romAddrHigh = 0;
        repeat (3) @(posedge clock);
        reset_n <= 1;
        @(posedge clock);
        rd(sdcu_pkg::MCC_FOUR_OFFSET);
        rd(sdcu_pkg::MCC_THREE_OFFSET);
        rd(8'h40);
        repeat (4)
        begin
            wr(sdcu_pkg::MCC_FOUR_OFFSET, $random(seed));
            rd(sdcu_pkg::MCC_FOUR_OFFSET);
        end
        for (int i = 0; i < 4; i++)
        begin
            wr(sdcu_pkg::MCC_FOUR_OFFSET, {8'h23, i[0], i[1], i[1], i[0], 20'h0});
            @(negedge clock);
            chk("inlineEcc", i == 2, inlineEccActive);
            chk("registeredBuf", i == 1, registeredBufActive);
            @(posedge clock);
            romReq <= 1; romAddrHigh <= 1;
            @(negedge clock);
            chk("romInRange", i[1], romInRange);
            @(posedge clock);
            romReq <= 0;
            starts = 0;
            n = 0;
            // sample between edges so registered pulses are settled
            repeat (8) @(negedge clock)
            begin
                starts += (romBurstStart === 1'b1);
                n += (romSelect === 1'b1);
            end
            chk("romBursts", i[1] ? 2 - i[0] : 0, starts);
            chk("romSelect", i[1] ? 2 - i[0] : 0, n);
        end
        wr(sdcu_pkg::MCC_THREE_OFFSET, 32'hF000_0000);
        for (int r = 0; r < 2; r++)
        begin
            wr(sdcu_pkg::MCC_FOUR_OFFSET, {8'h35, 4'h4, 2'h3, 2'h0, r[0], 11'h0, 4'hF});
            repeat (50)
            begin
                acc();
                repeat (20) @(posedge clock);
                chk("pageOpen", 1, pageOpen);
            end
            n = 21;
            while (!(sdramCmd.rowStrobeN === 1'b0 && sdramCmd.writeEnableN === 1'b0) && n < 1100)
            begin
                n++;
                @(posedge clock);
            end
            chk("closeDelay", 1, n >= 1022 && n <= 1030);
            chk("writeCount", expQ.size(), i_mem.capQ.size());
            while (expQ.size() > 0 && i_mem.capQ.size() > 0)
                chk("writeData", expQ.pop_front(), i_mem.capQ.pop_front());
            expQ.delete();
            i_mem.capQ.delete();
        end
        end_of_test;
    end
endmodule : test_sdram_ctrl_config_upper
